/* File: include/mem_host_cfg.svh */
// constants of the reduced memory port host controller
`ifndef MEM_HOST_CFG_SVH
`define MEM_HOST_CFG_SVH
// ==========================================
// widths of the memory port fields
`define ID_W 4
`define LEN_W 4
`define DEF_ID 4'h0
`define REG_AW 5
// ==========================================
// software register offsets
`define OFS_CTRL 5'h00
`define OFS_ADDR 5'h04
`define OFS_WDATA 5'h08
`define OFS_WSTRB 5'h0c
`define OFS_STATUS 5'h10
`define OFS_RDATA 5'h14
`define OFS_RCOUNT 5'h18
// ==========================================
// control register fields
`define CTRL_GO_WR 0
`define CTRL_GO_RD 1
`define CTRL_AP 2
`define CTRL_ID_EN 3
`define CTRL_ID_LSB 4
`define CTRL_LEN_LSB 8
`define CTRL_W 12
`define CTRL_GO_MASK 12'h003
// ==========================================
// status register fields
`define SB_INIT 0
`define SB_WR_BUSY 1
`define SB_RD_BUSY 2
`define SB_WR_DONE 3
`define SB_RD_DONE 4
`define SB_LAST_ERR 5
`define SB_ID_ERR 6
`define SB_REFUSED 7
`define SB_RID_LSB 8
// ==========================================
// reset values and bus answers
`define CTRL_RST 12'h000
`define ADDR_RST 32'h0000_0000
`define WDATA_RST 32'h0000_0000
`define WSTRB_RST 4'hf
`define RCOUNT_RST 16'h0000
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

/* File: include/mem_host_pkg.sv */
// types of the reduced memory port host controller
`include "mem_host_cfg.svh"
package mem_host_pkg;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_ADDR = 2'b01, ST_DATA = 2'b11} chan_state_t;
  typedef logic [`ID_W-1:0] req_id_t;
  typedef logic [`LEN_W-1:0] burst_len_t;
endpackage : mem_host_pkg

/* File: verilog/burst_beats.sv */
// beat counter of one burst, checks the device's last marker
module burst_beats #(
  parameter int LEN_W = 4
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // burst control
  input wire logic load,
  input wire logic [LEN_W-1:0] len,
  input wire logic beat,
  input wire logic last_in,
  // result
  output logic [LEN_W-1:0] count,
  output logic final_beat,
  output logic last_mismatch
);
  // ==========================================
  // elaboration check
  if (LEN_W < 1) begin : bad_len
    $error("LEN_W must be at least 1");
  end

  // ==========================================
  // counting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
    end else if (load) begin
      count <= '0;
    end else if (beat) begin
      count <= count + 1'b1;
    end
  end

  // a burst holds len plus one beats
  assign final_beat = (count == len);
  assign last_mismatch = beat && (last_in != final_beat);

  // ==========================================
  // checks
  count_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) load |=> count == '0)
    else $error("beat count not cleared on load");
endmodule : burst_beats

/* File: verilog/mem_port_host.sv */
// host controller driving the reduced memory port from software registers
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`include "mem_host_cfg.svh"
module mem_port_host
  import mem_host_pkg::*;
#(
  parameter int ADDR_W = 28,
  parameter int DATA_W = 32
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // software register bus
  input wire logic [`REG_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`REG_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // device status
  input wire logic init_done,
  // write address channel
  output logic [ADDR_W-1:0] wr_addr,
  output logic wr_autoprecharge,
  output req_id_t wr_req_id,
  output burst_len_t wr_len,
  output logic wr_addr_valid,
  input wire logic wr_addr_ready,
  // read address channel
  output logic [ADDR_W-1:0] rd_addr,
  output logic rd_autoprecharge,
  output req_id_t rd_req_id,
  output burst_len_t rd_len,
  output logic rd_addr_valid,
  input wire logic rd_addr_ready,
  // write data channel
  output logic [DATA_W-1:0] wr_data,
  output logic [DATA_W/8-1:0] wr_strb,
  input wire logic wr_data_ready,
  input wire req_id_t wr_data_id_out,
  input wire logic wr_data_last,
  // read data channel
  input wire logic [DATA_W-1:0] rd_data,
  input wire req_id_t rd_data_id,
  input wire logic rd_data_last,
  input wire logic rd_data_valid
);
  // ==========================================
  // elaboration checks
  if (DATA_W != 32) begin : bad_data
    $error("DATA_W must be 32, one register word per beat");
  end
  if (ADDR_W < 1 || ADDR_W > 32) begin : bad_addr
    $error("ADDR_W must be 1 to 32");
  end

  // ==========================================
  // declarations
  chan_state_t wr_state, next_wr_state, rd_state, next_rd_state;
  logic aw_q, w_q;
  logic [`REG_AW-1:0] awaddr_q, wa;
  logic [31:0] wdata_q, wd, next_ctrl, rd_mux, status_word;
  logic [3:0] wstrb_q, ws;
  logic aw_take, w_take, do_wr, wr_hit, rd_hit;
  logic [`CTRL_W-1:0] ctrl_q;
  logic [31:0] addr_q, pattern_q, rdata_last;
  logic [3:0] strb_q;
  logic [15:0] rd_total;
  req_id_t last_rid;
  logic sel_ctrl, sel_addr, sel_wdata, sel_wstrb, sel_status;
  logic go_wr, go_rd, wr_start, rd_start;
  logic wr_beat, rd_beat, wr_final, rd_final, wr_last_bad, rd_last_bad;
  logic wr_done_q, rd_done_q, last_err_q, id_err_q, refused_q;
  logic last_err_set, id_err_set, refused_set;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction : merge

  // ==========================================
  // register bus: write side, address and data in either order
  assign awready = !aw_q && !bvalid;
  assign wready = !w_q && !bvalid;
  assign aw_take = awvalid && awready;
  assign w_take = wvalid && wready;
  assign do_wr = (aw_q || aw_take) && (w_q || w_take) && !bvalid;
  assign wa = aw_q ? awaddr_q : awaddr;
  assign wd = w_q ? wdata_q : wdata;
  assign ws = w_q ? wstrb_q : wstrb;
  assign sel_ctrl = do_wr && (wa == `OFS_CTRL);
  assign sel_addr = do_wr && (wa == `OFS_ADDR);
  assign sel_wdata = do_wr && (wa == `OFS_WDATA);
  assign sel_wstrb = do_wr && (wa == `OFS_WSTRB);
  assign sel_status = do_wr && (wa == `OFS_STATUS);
  assign wr_hit = (wa == `OFS_CTRL) || (wa == `OFS_ADDR) || (wa == `OFS_WDATA) || (wa == `OFS_WSTRB)
                  || (wa == `OFS_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      aw_q <= !do_wr && (aw_q || aw_take);
      w_q <= !do_wr && (w_q || w_take);
      if (aw_take) begin
        awaddr_q <= awaddr;
      end
      if (w_take) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (do_wr) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ==========================================
  // register bus: read side
  assign arready = !rvalid;
  assign status_word[`SB_INIT] = init_done;
  assign status_word[`SB_WR_BUSY] = (wr_state != ST_IDLE);
  assign status_word[`SB_RD_BUSY] = (rd_state != ST_IDLE);
  assign status_word[`SB_WR_DONE] = wr_done_q;
  assign status_word[`SB_RD_DONE] = rd_done_q;
  assign status_word[`SB_LAST_ERR] = last_err_q;
  assign status_word[`SB_ID_ERR] = id_err_q;
  assign status_word[`SB_REFUSED] = refused_q;
  assign status_word[`SB_RID_LSB +: `ID_W] = last_rid;
  assign status_word[31:`SB_RID_LSB+`ID_W] = '0;
  assign rd_hit = (araddr == `OFS_CTRL) || (araddr == `OFS_ADDR) || (araddr == `OFS_WDATA)
                  || (araddr == `OFS_WSTRB) || (araddr == `OFS_STATUS) || (araddr == `OFS_RDATA)
                  || (araddr == `OFS_RCOUNT);
  assign rd_mux = (araddr == `OFS_CTRL) ? {20'h00000, ctrl_q} :
                  (araddr == `OFS_ADDR) ? addr_q :
                  (araddr == `OFS_WDATA) ? pattern_q :
                  (araddr == `OFS_WSTRB) ? {28'h0000000, strb_q} :
                  (araddr == `OFS_STATUS) ? status_word :
                  (araddr == `OFS_RDATA) ? rdata_last :
                  (araddr == `OFS_RCOUNT) ? {16'h0000, rd_total} : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rd_mux;
      rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ==========================================
  // software registers
  assign next_ctrl = merge({20'h00000, ctrl_q}, wd, ws);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `CTRL_RST;
      addr_q <= `ADDR_RST;
      pattern_q <= `WDATA_RST;
      strb_q <= `WSTRB_RST;
    end else begin
      if (sel_ctrl) begin
        ctrl_q <= next_ctrl[`CTRL_W-1:0] & ~`CTRL_GO_MASK;
      end
      if (sel_addr) begin
        addr_q <= merge(addr_q, wd, ws);
      end
      if (sel_wdata) begin
        pattern_q <= merge(pattern_q, wd, ws);
      end
      if (sel_wstrb && ws[0]) begin
        strb_q <= wd[3:0];
      end
    end
  end

  // ==========================================
  // request start; init_done shares aclk, so it needs no synchroniser
  assign go_wr = sel_ctrl && ws[0] && wd[`CTRL_GO_WR];
  assign go_rd = sel_ctrl && ws[0] && wd[`CTRL_GO_RD];
  assign wr_start = go_wr && init_done && (wr_state == ST_IDLE);
  assign rd_start = go_rd && init_done && (rd_state == ST_IDLE);
  assign refused_set = (go_wr && !wr_start) || (go_rd && !rd_start);

  // request fields stay frozen from start to the end of the burst
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_addr <= '0;
      wr_autoprecharge <= 1'b0;
      wr_req_id <= `DEF_ID;
      wr_len <= '0;
      rd_addr <= '0;
      rd_autoprecharge <= 1'b0;
      rd_req_id <= `DEF_ID;
      rd_len <= '0;
    end else begin
      // flat address: the device splits it into row, bank and column and rounds at column ends
      // no size field is sent, the device works with its default burst size
      if (wr_start) begin
        wr_addr <= addr_q[ADDR_W-1:0];
        wr_autoprecharge <= next_ctrl[`CTRL_AP];
        wr_req_id <= next_ctrl[`CTRL_ID_EN] ? next_ctrl[`CTRL_ID_LSB +: `ID_W] : `DEF_ID;
        wr_len <= next_ctrl[`CTRL_LEN_LSB +: `LEN_W];
      end
      if (rd_start) begin
        rd_addr <= addr_q[ADDR_W-1:0];
        rd_autoprecharge <= next_ctrl[`CTRL_AP];
        rd_req_id <= next_ctrl[`CTRL_ID_EN] ? next_ctrl[`CTRL_ID_LSB +: `ID_W] : `DEF_ID;
        rd_len <= next_ctrl[`CTRL_LEN_LSB +: `LEN_W];
      end
    end
  end

  // ==========================================
  // channel state machines; data is counted only after the address is taken
  assign wr_addr_valid = (wr_state == ST_ADDR);
  assign rd_addr_valid = (rd_state == ST_ADDR);
  assign wr_beat = wr_data_ready && (wr_state == ST_DATA);
  assign rd_beat = rd_data_valid && (rd_state == ST_DATA);

  always_comb begin
    next_wr_state = wr_state;
    unique case (wr_state)
      ST_IDLE: next_wr_state = wr_start ? ST_ADDR : ST_IDLE;
      ST_ADDR: next_wr_state = wr_addr_ready ? ST_DATA : ST_ADDR;
      ST_DATA: next_wr_state = (wr_beat && wr_final) ? ST_IDLE : ST_DATA;
      default: next_wr_state = ST_IDLE;
    endcase
  end

  always_comb begin
    next_rd_state = rd_state;
    unique case (rd_state)
      ST_IDLE: next_rd_state = rd_start ? ST_ADDR : ST_IDLE;
      ST_ADDR: next_rd_state = rd_addr_ready ? ST_DATA : ST_ADDR;
      ST_DATA: next_rd_state = (rd_beat && rd_final) ? ST_IDLE : ST_DATA;
      default: next_rd_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= ST_IDLE;
      rd_state <= ST_IDLE;
    end else begin
      wr_state <= next_wr_state;
      rd_state <= next_rd_state;
    end
  end

  burst_beats #(.LEN_W(`LEN_W)) u_wr_beats (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(wr_start),
    .len(wr_len),
    .beat(wr_beat),
    .last_in(wr_data_last),
    .count(),
    .final_beat(wr_final),
    .last_mismatch(wr_last_bad)
  );

  burst_beats #(.LEN_W(`LEN_W)) u_rd_beats (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(rd_start),
    .len(rd_len),
    .beat(rd_beat),
    .last_in(rd_data_last),
    .count(),
    .final_beat(rd_final),
    .last_mismatch(rd_last_bad)
  );

  // ==========================================
  // write beats: next data word is ready before the next ready; no write response exists
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_data <= '0;
      wr_strb <= '0;
    end else if (wr_start) begin
      wr_data <= pattern_q;
      wr_strb <= strb_q;
    end else if (wr_beat) begin
      wr_data <= wr_data + 1'b1;
    end
  end

  // read beats are taken unconditionally, there is no way to stall them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_last <= '0;
      last_rid <= `DEF_ID;
      rd_total <= `RCOUNT_RST;
    end else if (rd_beat) begin
      rdata_last <= rd_data;
      last_rid <= rd_data_id;
      rd_total <= rd_total + 16'h0001;
    end
  end

  // ==========================================
  // sticky status, write one to clear, a new event wins over the clear
  assign last_err_set = wr_last_bad || rd_last_bad || (wr_data_ready && wr_state != ST_DATA)
                        || (rd_data_valid && rd_state != ST_DATA);
  assign id_err_set = (wr_beat && wr_data_id_out != wr_req_id) || (rd_beat && rd_data_id != rd_req_id);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_done_q <= 1'b0;
      rd_done_q <= 1'b0;
      last_err_q <= 1'b0;
      id_err_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      wr_done_q <= (wr_beat && wr_final) || (wr_done_q && !(sel_status && ws[0] && wd[`SB_WR_DONE]));
      rd_done_q <= (rd_beat && rd_final) || (rd_done_q && !(sel_status && ws[0] && wd[`SB_RD_DONE]));
      last_err_q <= last_err_set || (last_err_q && !(sel_status && ws[0] && wd[`SB_LAST_ERR]));
      id_err_q <= id_err_set || (id_err_q && !(sel_status && ws[0] && wd[`SB_ID_ERR]));
      refused_q <= refused_set || (refused_q && !(sel_status && ws[0] && wd[`SB_REFUSED]));
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence aw_wait_s;
    wr_addr_valid && !wr_addr_ready;
  endsequence
  sequence ar_wait_s;
    rd_addr_valid && !rd_addr_ready;
  endsequence
  property aw_hold_p;
    aw_wait_s |=> wr_addr_valid && $stable(wr_addr) && $stable(wr_req_id) && $stable(wr_len)
                  && $stable(wr_autoprecharge);
  endproperty
  property ar_hold_p;
    ar_wait_s |=> rd_addr_valid && $stable(rd_addr) && $stable(rd_req_id) && $stable(rd_len)
                  && $stable(rd_autoprecharge);
  endproperty

  aw_hold_a: assert property (aw_hold_p)
    else $error("write request changed before handshake");
  ar_hold_a: assert property (ar_hold_p)
    else $error("read request changed before handshake");
  aw_release_a: assert property (wr_addr_valid && wr_addr_ready |=> !wr_addr_valid ##0 wr_state == ST_DATA)
    else $error("write address not released after handshake");
  ar_release_a: assert property (rd_addr_valid && rd_addr_ready |=> !rd_addr_valid ##0 rd_state == ST_DATA)
    else $error("read address not released after handshake");
  init_gate_a: assert property (($rose(wr_addr_valid) || $rose(rd_addr_valid)) |-> $past(init_done))
    else $error("request issued before init done");
  wr_end_a: assert property (wr_beat && wr_final |=> wr_state == ST_IDLE && wr_done_q)
    else $error("write burst did not end on its final beat");
  rd_end_a: assert property (rd_beat && rd_final |=> rd_state == ST_IDLE && rd_done_q)
    else $error("read burst did not end on its final beat");
  wdata_step_a: assert property (wr_beat |=> wr_data == $past(wr_data) + DATA_W'(1))
    else $error("write data not advanced after beat");
  rd_take_a: assert property (rd_beat |=> rdata_last == $past(rd_data)
                              && rd_total == $past(rd_total) + 16'h0001)
    else $error("read beat not captured");
  id_tie_a: assert property (wr_start && !next_ctrl[`CTRL_ID_EN] |=> wr_req_id == `DEF_ID)
    else $error("unused write id not tied to constant");
endmodule : mem_port_host

/* File: bench/mem_dev_model.sv */
// device side model of the reduced memory port
module mem_dev_model
  import mem_host_pkg::*;
#(
  parameter int INIT_CYC = 80
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // scenario controls
  input wire logic slow,
  input wire logic bad_last,
  // device status
  output logic init_done,
  // write address channel
  input wire logic [27:0] wr_addr,
  input wire logic wr_autoprecharge,
  input wire req_id_t wr_req_id,
  input wire burst_len_t wr_len,
  input wire logic wr_addr_valid,
  output logic wr_addr_ready,
  // read address channel
  input wire logic [27:0] rd_addr,
  input wire logic rd_autoprecharge,
  input wire req_id_t rd_req_id,
  input wire burst_len_t rd_len,
  input wire logic rd_addr_valid,
  output logic rd_addr_ready,
  // write data channel
  input wire logic [31:0] wr_data,
  input wire logic [3:0] wr_strb,
  output logic wr_data_ready,
  output req_id_t wr_data_id_out,
  output logic wr_data_last,
  // read data channel
  output logic [31:0] rd_data,
  output req_id_t rd_data_id,
  output logic rd_data_last,
  output logic rd_data_valid,
  // observation
  output logic [8:0] wr_seen,
  output logic [8:0] rd_seen,
  output logic proto_err
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // answers
  logic [31:0] mem [16];
  logic [7:0] icnt;
  logic tick, go, wact, ract, wwait, rwait, host_bad;
  logic [3:0] wk, wl, wbase, rk, rl, rbase;
  logic [36:0] wfld, rfld, wprev, rprev;
  req_id_t wid, rid;
  // slow mode answers every other cycle only
  assign go = !slow || tick;
  assign init_done = icnt == INIT_CYC[7:0];
  assign wr_addr_ready = go;
  assign rd_addr_ready = go;
  assign wr_data_ready = wact && go;
  // in the fault scenario the misplaced last beat also carries a wrong id
  assign wr_data_id_out = wr_data_ready ? wid ^ {3'h0, bad_last && wr_data_last} : {4{tick}};
  assign wr_data_last = wr_data_ready && (wk == (bad_last ? wl - 4'h1 : wl));
  assign rd_data_valid = ract && go;
  assign rd_data_last = rd_data_valid && rk == rl;
  assign rd_data_id = rd_data_valid ? rid : {4{tick}};
  // released lines toggle so a stale value never passes
  assign rd_data = rd_data_valid ? mem[rbase + rk] : {32{tick}};
  assign wfld = {wr_addr, wr_autoprecharge, wr_req_id, wr_len};
  assign rfld = {rd_addr, rd_autoprecharge, rd_req_id, rd_len};
  assign host_bad = (wwait && (!wr_addr_valid || wfld != wprev)) || (rwait && (!rd_addr_valid || rfld != rprev))
    || (!init_done && (wr_addr_valid || rd_addr_valid));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      icnt <= 8'h00;
      tick <= 1'b0;
      wact <= 1'b0;
      ract <= 1'b0;
      wwait <= 1'b0;
      rwait <= 1'b0;
      proto_err <= 1'b0;
      wr_seen <= 9'h000;
      rd_seen <= 9'h000;
      for (int i = 0; i < 16; i++) mem[i] <= 32'h0;
    end else begin
      tick <= ~tick;
      if (!init_done) icnt <= icnt + 8'h01;
      wwait <= wr_addr_valid && !wr_addr_ready;
      rwait <= rd_addr_valid && !rd_addr_ready;
      wprev <= wfld;
      rprev <= rfld;
      if (host_bad) proto_err <= 1'b1;
      if (wr_addr_valid && go && !wact) begin
        wact <= 1'b1;
        wk <= 4'h0;
        wl <= wr_len;
        wid <= wr_req_id;
        wbase <= wr_addr[3:0];
        wr_seen <= {wr_autoprecharge, wr_req_id, wr_len};
      end
      if (wr_data_ready) begin
        for (int b = 0; b < 4; b++) if (wr_strb[b]) mem[wbase + wk][8*b +: 8] <= wr_data[8*b +: 8];
        wk <= wk + 4'h1;
        if (wk == wl) wact <= 1'b0;
      end
      if (rd_addr_valid && go && !ract) begin
        ract <= 1'b1;
        rk <= 4'h0;
        rl <= rd_len;
        rid <= rd_req_id;
        rbase <= rd_addr[3:0];
        rd_seen <= {rd_autoprecharge, rd_req_id, rd_len};
      end
      if (rd_data_valid) begin
        rk <= rk + 4'h1;
        if (rk == rl) ract <= 1'b0;
      end
    end
  end
endmodule : mem_dev_model

/* File: bench/mem_port_host_test.sv */
// self-checking bench of the memory port host controller
`include "mem_host_cfg.svh"
module mem_port_host_test
  import mem_host_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // signals
  logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b0, bad_last = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, init_done, proto_err;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, wr_data, rd_data;
  logic [27:0] wr_addr, rd_addr;
  logic [3:0] wr_strb;
  logic wr_autoprecharge, wr_addr_valid, wr_addr_ready, rd_autoprecharge, rd_addr_valid, rd_addr_ready;
  logic wr_data_ready, wr_data_last, rd_data_last, rd_data_valid;
  req_id_t wr_req_id, rd_req_id, wr_data_id_out, rd_data_id;
  req_id_t last_rid = 4'h0;
  burst_len_t wr_len, rd_len;
  logic [8:0] wr_seen, rd_seen;
  logic [15:0] rcnt = 16'h0;
  int error_cnt = 0, cmp_count = 0;
  mem_port_host dut (.*);
  mem_dev_model #(.INIT_CYC(80)) model (.*);
  always #25 aclk = ~aclk;
  // ==========================================
  // tasks
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("compares=%0d mismatches=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize
  task automatic bus_wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    r = bresp;
    bready <= 1'b0;
    if (n == 64) begin
      chk(34'h0, 34'h1);
      summarize();
    end
  endtask : bus_wr
  task automatic bus_rd(input logic [4:0] a, output logic [1:0] r, output logic [31:0] d);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    r = rresp;
    d = rdata;
    rready <= 1'b0;
    if (n == 64) begin
      chk(34'h0, 34'h1);
      summarize();
    end
  endtask : bus_rd
  task automatic reg_wr(input logic [4:0] a, input logic [31:0] d);
    logic [1:0] r;
    bus_wr(a, d, 4'hf, r);
    chk({32'h0, r}, {32'h0, `RESP_OKAY});
  endtask : reg_wr
  task automatic reg_chk(input logic [4:0] a, input logic [31:0] e);
    logic [1:0] r;
    logic [31:0] d;
    bus_rd(a, r, d);
    chk({r, d}, {`RESP_OKAY, e});
  endtask : reg_chk
  task automatic start(input logic rd, ap, ide, input logic [3:0] id, len);
    reg_wr(`OFS_CTRL, {20'h0, len, id, ide, ap, rd, !rd});
  endtask : start
  task automatic wait_st(input int b);
    logic [1:0] r;
    logic [31:0] d;
    int n;
    for (n = 0; n < 200; n++) begin
      bus_rd(`OFS_STATUS, r, d);
      if (d[b] === 1'b1) break;
    end
    if (n == 200) begin
      chk(34'h0, 34'h1);
      summarize();
    end
  endtask : wait_st
  // write a burst, read it back, check the last word and the counts
  task automatic run_case(input logic s, ap, ide, input logic [3:0] id, len, strb, input logic [31:0] pat, ad, e);
    req_id_t eid;
    eid = ide ? id : 4'h0;
    @(posedge aclk);
    slow <= s;
    reg_wr(`OFS_ADDR, ad);
    reg_wr(`OFS_WDATA, pat);
    reg_wr(`OFS_WSTRB, {28'h0, strb});
    start(1'b0, ap, ide, id, len);
    wait_st(`SB_WR_DONE);
    reg_chk(`OFS_STATUS, {20'h0, last_rid, 8'h09});
    chk({25'h0, wr_seen}, {25'h0, ap, eid, len});
    reg_wr(`OFS_STATUS, 32'hf8);
    start(1'b1, ap, ide, id, len);
    wait_st(`SB_RD_DONE);
    last_rid = eid;
    rcnt = rcnt + 16'(len) + 16'h1;
    reg_chk(`OFS_STATUS, {20'h0, eid, 8'h11});
    reg_chk(`OFS_RDATA, e);
    reg_chk(`OFS_RCOUNT, {16'h0, rcnt});
    chk({25'h0, rd_seen}, {25'h0, ap, eid, len});
    reg_wr(`OFS_STATUS, 32'hf8);
    $display("case done len=%0d slow=%0d", len, s);
  endtask : run_case
  // ==========================================
  // sequence
  initial begin
    logic [1:0] r;
    logic [31:0] d;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    reg_chk(`OFS_CTRL, 32'h0);
    reg_chk(`OFS_ADDR, 32'h0);
    reg_chk(`OFS_WDATA, 32'h0);
    reg_chk(`OFS_WSTRB, 32'hf);
    reg_chk(`OFS_RCOUNT, 32'h0);
    reg_chk(`OFS_STATUS, 32'h0);
    bus_rd(5'h1c, r, d);
    chk({r, d}, {`RESP_SLVERR, 32'h0});
    bus_wr(5'h1c, 32'h1, 4'hf, r);
    chk({32'h0, r}, {32'h0, `RESP_SLVERR});
    start(1'b0, 1'b0, 1'b0, 4'h0, 4'h0);
    reg_chk(`OFS_STATUS, 32'h80);
    reg_wr(`OFS_STATUS, 32'hf8);
    wait_st(`SB_INIT);
    reg_chk(`OFS_STATUS, 32'h1);
    $display("reset test done");
    run_case(1'b0, 1'b1, 1'b1, 4'h5, 4'h3, 4'hf, 32'h1000_0000, 32'h4, 32'h1000_0003);
    run_case(1'b1, 1'b0, 1'b1, 4'ha, 4'hf, 4'hf, 32'ha0a0_0000, 32'h0, 32'ha0a0_000f);
    run_case(1'b1, 1'b1, 1'b0, 4'h7, 4'h0, 4'h3, 32'h55aa_1234, 32'h2, 32'ha0a0_1234);
    // a wrongly placed last marker and a go while busy
    @(posedge aclk);
    bad_last <= 1'b1;
    reg_wr(`OFS_WSTRB, 32'hf);
    start(1'b0, 1'b0, 1'b0, 4'h0, 4'hf);
    start(1'b0, 1'b0, 1'b0, 4'h0, 4'hf);
    reg_chk(`OFS_STATUS, {20'h0, last_rid, 8'h83});
    wait_st(`SB_WR_DONE);
    reg_chk(`OFS_STATUS, {20'h0, last_rid, 8'he9});
    reg_chk(`OFS_CTRL, 32'hf00);
    reg_chk(`OFS_WDATA, 32'h55aa_1234);
    $display("fault test done");
    chk({33'h0, proto_err}, 34'h0);
    summarize();
  end
endmodule : mem_port_host_test
